// file: inc/ccs_pkg.sv
`default_nettype none
package ccs_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [15:0] CPU_CLOCK_CONTROL_ADDR = 16'hFFFB;
  localparam logic [7:0]  CPU_CLOCK_CONTROL_RST  = 8'h04;
  localparam int          MAIN_OSC_STOP_BIT      = 7;
  localparam int          ACTIVE_CLOCK_FLAG_BIT  = 5;
  localparam int          SUBCLOCK_SELECT_BIT    = 4;
  localparam int          ZERO_BIT3              = 3;
  localparam int          DIV_SEL_LSB            = 0;
  localparam int          DIV_SEL_W              = 3;
  localparam logic [7:0]  WRITABLE_MASK          = 8'h97;

  // ------------------------------------------------------------
  // Divider codes and timing
  // ------------------------------------------------------------
  localparam logic [2:0]  DIV_1                  = 3'h0;
  localparam logic [2:0]  DIV_16                 = 3'h4;
  localparam int          DIV_STAGES             = 5;
  localparam int          OSC_STAB_EXP           = 17;
  localparam int          SWITCH_INSTR_MAX       = 16;
  localparam int          CLKS_PER_INSTR         = 2;

  typedef enum logic [2:0] {
    CCS_MAIN    = 3'b001,
    CCS_TO_SUB  = 3'b010,
    CCS_SUB     = 3'b100
  } ccs_state_t;

  typedef struct packed {
    logic       wr_en;
    logic       bit_en;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ccs_wr_t;

endpackage : ccs_pkg
`default_nettype wire

// file: src/ccs_clock_select.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_clock_select #(
  parameter int STAB_CYCLES  = 2 ** ccs_pkg::OSC_STAB_EXP,
  parameter int SWITCH_DELAY = ccs_pkg::SWITCH_INSTR_MAX * ccs_pkg::CLKS_PER_INSTR
) (
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  input  wire ccs_pkg::ccs_wr_t wr,
  input  wire logic            rd_en,
  input  wire logic            stop_instr,
  input  wire logic            halt_instr,
  input  wire logic            wake,
  input  wire logic            sub_clk_in,
  output logic [7:0]           rdata,
  output logic                 cpu_clk_en,
  output logic                 main_osc_run,
  output logic                 sub_osc_run,
  output logic                 cpu_run,
  output logic                 halted,
  output logic                 wdt_count_en
);

  // ------------------------------------------------------------
  // Register and state
  // ------------------------------------------------------------
  logic                   main_osc_stop_r;
  logic                   subclock_select_r;
  logic [2:0]             div_sel_r;
  logic [2:0]             div_act_r;
  ccs_pkg::ccs_state_t    state_r;
  logic [$clog2(SWITCH_DELAY+1)-1:0] sw_cnt_r;
  logic [$clog2(STAB_CYCLES+1)-1:0]  stab_cnt_r;
  logic                   stopped_r;
  logic                   halt_r;
  logic [3:0]             div_cnt_r;
  logic [1:0]             sub_sync_r;
  logic                   sub_prev_r;
  logic [7:0]             reg_view;
  logic [7:0]             wval;
  logic                   hit;
  logic                   on_sub;
  logic                   main_tick;
  logic                   sub_tick;
  logic                   main_osc_nxt;

  assign hit    = wr.wr_en && (wr.addr == ccs_pkg::CPU_CLOCK_CONTROL_ADDR);
  assign on_sub = (state_r == ccs_pkg::CCS_SUB);

  always_comb begin
    reg_view = 8'h00;
    reg_view[ccs_pkg::MAIN_OSC_STOP_BIT]     = main_osc_stop_r;
    reg_view[ccs_pkg::ACTIVE_CLOCK_FLAG_BIT] = on_sub;
    reg_view[ccs_pkg::SUBCLOCK_SELECT_BIT]   = subclock_select_r;
    reg_view[ccs_pkg::DIV_SEL_LSB +: ccs_pkg::DIV_SEL_W] = div_sel_r;
  end

  // Bit write merges one bit into current value
  always_comb begin
    wval = reg_view;
    if (wr.bit_en) begin
      wval[wr.bit_idx] = wr.bit_val;
    end else begin
      wval = wr.wdata;
    end
    wval = wval & ccs_pkg::WRITABLE_MASK;
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_stop_r   <= ccs_pkg::CPU_CLOCK_CONTROL_RST[ccs_pkg::MAIN_OSC_STOP_BIT];
      subclock_select_r <= ccs_pkg::CPU_CLOCK_CONTROL_RST[ccs_pkg::SUBCLOCK_SELECT_BIT];
      div_sel_r         <= ccs_pkg::CPU_CLOCK_CONTROL_RST[2:0];
    end else if (hit) begin
      main_osc_stop_r   <= wval[ccs_pkg::MAIN_OSC_STOP_BIT];
      subclock_select_r <= wval[ccs_pkg::SUBCLOCK_SELECT_BIT];
      div_sel_r         <= wval[ccs_pkg::DIV_SEL_LSB +: ccs_pkg::DIV_SEL_W];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= ccs_pkg::CPU_CLOCK_CONTROL_RST;
    end else if (rd_en) begin
      rdata <= reg_view;
    end
  end

  // ------------------------------------------------------------
  // Divider switch and switch to sub, delayed SWITCH_DELAY ref_clk cycles; return to main only waits for a main tick
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ccs_pkg::CCS_MAIN;
      sw_cnt_r  <= '0;
      div_act_r <= ccs_pkg::DIV_16;
    end else begin
      case (state_r)
        ccs_pkg::CCS_MAIN: begin
          if (div_act_r != div_sel_r) begin
            if (sw_cnt_r == ($bits(sw_cnt_r))'(SWITCH_DELAY)) begin
              div_act_r <= div_sel_r;
              sw_cnt_r  <= '0;
            end else begin
              sw_cnt_r <= sw_cnt_r + 1'b1;
            end
          end else if (subclock_select_r) begin
            state_r  <= ccs_pkg::CCS_TO_SUB;
            sw_cnt_r <= '0;
          end else begin
            sw_cnt_r <= '0;
          end
        end
        ccs_pkg::CCS_TO_SUB: begin
          if (!subclock_select_r) begin
            state_r <= ccs_pkg::CCS_MAIN;
          end else if (sw_cnt_r == ($bits(sw_cnt_r))'(SWITCH_DELAY) && sub_tick) begin
            state_r <= ccs_pkg::CCS_SUB;
          end else if (sw_cnt_r != ($bits(sw_cnt_r))'(SWITCH_DELAY)) begin
            sw_cnt_r <= sw_cnt_r + 1'b1;
          end
        end
        ccs_pkg::CCS_SUB: begin
          // Return waits for running main oscillator and edge alignment
          if (!subclock_select_r && main_osc_run && main_tick) begin
            state_r   <= ccs_pkg::CCS_MAIN;
            div_act_r <= div_sel_r;
            sw_cnt_r  <= '0;
          end
        end
        default: begin
          state_r <= ccs_pkg::CCS_MAIN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Clock enables: main divider and sub clock over two
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= '0;
    end else if (main_osc_run) begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  always_comb begin
    main_tick = 1'b0;
    if (main_osc_run && div_act_r <= ccs_pkg::DIV_16) begin
      main_tick = ((div_cnt_r & ((4'h1 << div_act_r) - 4'h1)) == 4'h0);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_sync_r <= 2'b00;
      sub_prev_r <= 1'b0;
    end else begin
      sub_sync_r <= {sub_sync_r[0], sub_clk_in};
      if (sub_sync_r[1] && !sub_prev_r) begin
        sub_prev_r <= 1'b1;
      end else if (!sub_sync_r[1]) begin
        sub_prev_r <= 1'b0;
      end
    end
  end

  // One tick per two sub clock periods, i.e. sub frequency over two
  logic sub_half_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sub_half_r <= 1'b0;
    end else if (sub_sync_r[1] && !sub_prev_r) begin
      sub_half_r <= !sub_half_r;
    end
  end
  assign sub_tick = sub_sync_r[1] && !sub_prev_r && sub_half_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= on_sub ? (sub_tick && !halt_r)
                           : (main_tick && cpu_run && !halt_r);
    end
  end

  // ------------------------------------------------------------
  // Oscillators, standby and stabilisation
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopped_r <= 1'b0;
      halt_r    <= 1'b0;
    end else begin
      // Entry wins over a wake in the same cycle
      if (stop_instr && !on_sub) begin
        stopped_r <= 1'b1;
      end else if (wake) begin
        stopped_r <= 1'b0;
      end
      if (halt_instr) begin
        halt_r <= 1'b1;
      end else if (wake) begin
        halt_r <= 1'b0;
      end
    end
  end

  always_comb begin
    main_osc_nxt = !stopped_r;
    if (main_osc_stop_r && on_sub) begin
      main_osc_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_run <= 1'b0;
      sub_osc_run  <= 1'b1;
    end else begin
      main_osc_run <= main_osc_nxt;
      sub_osc_run  <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stab_cnt_r <= '0;
      cpu_run    <= 1'b0;
    end else if (!cpu_run) begin
      if (stab_cnt_r == ($bits(stab_cnt_r))'(STAB_CYCLES - 1)) begin
        cpu_run <= 1'b1;
      end else begin
        stab_cnt_r <= stab_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      halted       <= 1'b0;
      wdt_count_en <= 1'b0;
    end else begin
      halted       <= halt_r || stopped_r;
      wdt_count_en <= cpu_run && !on_sub && !stopped_r;
    end
  end

endmodule : ccs_clock_select
`default_nettype wire

// file: verification/ccs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_checker (
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire ccs_pkg::ccs_wr_t wr,
  input wire logic             rd_en,
  input wire logic             stop_instr,
  input wire logic             halt_instr,
  input wire logic             wake,
  input wire logic             sub_clk_in,
  input wire logic [7:0]       rdata,
  input wire logic             cpu_clk_en,
  input wire logic             main_osc_run,
  input wire logic             sub_osc_run,
  input wire logic             cpu_run,
  input wire logic             halted,
  input wire logic             wdt_count_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------
  // Register view steps
  // ----------------------------
  sequence s_full_wr;
    wr.wr_en && !wr.bit_en && wr.addr == 16'hFFFB;
  endsequence
  sequence s_rd_done;
    $past(rd_en);
  endsequence
  a_sub_osc_on: assert property (sub_osc_run) else $error("sub osc off");
  a_reset_load: assert property ($rose(reset_n) |-> rdata == 8'h04 && !main_osc_run)
    else $error("bad state after reset");
  a_zero_bits: assert property (!rdata[6] && !rdata[3]) else $error("fixed bit set");
  a_write_take: assert property (s_full_wr ##2 rd_en |=>
    {rdata[7], rdata[4], rdata[2:0]} ==
      {$past(wr.wdata[7], 3), $past(wr.wdata[4], 3), $past(wr.wdata[2:0], 3)})
    else $error("written byte not read back");
  a_sub_no_wdt: assert property (s_rd_done ##0 rdata[5] |-> !wdt_count_en)
    else $error("watchdog counts on sub clock");
  a_sub_osc_stop: assert property (s_rd_done ##0 rdata[7] && rdata[5] |-> ##[0:2] !main_osc_run)
    else $error("main osc not stopped");
  a_mcc_keep_main: assert property (s_rd_done ##0 rdata[7] && !rdata[5] && !halted |-> main_osc_run)
    else $error("main osc stopped on main clock");
  a_stop_main: assert property (stop_instr && wdt_count_en |-> ##[1:3] halted && !main_osc_run)
    else $error("stop mode not entered");
  a_halt_enter: assert property (halt_instr && cpu_run && !halted |-> ##[1:2] halted)
    else $error("halt mode not entered");
endmodule : ccs_checker
`default_nettype wire

// file: verification/ccs_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_cpu_model (
  input  wire logic ref_clk,
  input  wire logic cpu_clk_en,
  output var logic  sub_clk_in,
  output var int    ticks
);
  // Free-running sub oscillator, 20 ref cycles
  initial begin
    sub_clk_in = 1'b0;
    forever #40 sub_clk_in = ~sub_clk_in;
  end
  initial ticks = 0;
  always @(posedge ref_clk) begin
    if (cpu_clk_en === 1'b1) ticks <= ticks + 1;
  end
endmodule : ccs_cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic             ref_clk, reset_n, rd_en, stop_instr, halt_instr, wake, sub_clk_in;
  logic             cpu_clk_en, main_osc_run, sub_osc_run, cpu_run, halted, wdt_count_en;
  logic [7:0]       rdata, v;
  ccs_pkg::ccs_wr_t wr;
  int               n_errors, num_checks, ticks, t0, k;

  ccs_clock_select #(.STAB_CYCLES(16)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .wr(wr),
    .rd_en(rd_en), .stop_instr(stop_instr), .halt_instr(halt_instr), .wake(wake),
    .sub_clk_in(sub_clk_in), .rdata(rdata), .cpu_clk_en(cpu_clk_en), .cpu_run(cpu_run),
    .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run), .halted(halted),
    .wdt_count_en(wdt_count_en));
  ccs_cpu_model u_cpu (.ref_clk(ref_clk), .cpu_clk_en(cpu_clk_en), .sub_clk_in(sub_clk_in),
    .ticks(ticks));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic b, input logic [2:0] i, input logic [15:0] a,
                      input logic [7:0] d);
    cyc(1);
    wr = '{1'b1, b, i, d[0], a, d};
    cyc(1);
    wr.wr_en = 1'b0;
  endtask : wreg
  task automatic rd();
    cyc(1);
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    v = rdata;
  endtask : rd
  task automatic pulse(input int w);
    cyc(1);
    {stop_instr, halt_instr, wake} = 3'h4 >> w;
    cyc(1);
    {stop_instr, halt_instr, wake} = 3'h0;
  endtask : pulse
  task automatic poll(input logic f);
    k = 0;
    do begin
      rd();
      k++;
    end while (v[5] !== f && k < 100);
  endtask : poll
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset();
    k = 0;
    while (cpu_run !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    chk(8'(k), 8'h10);
    rd();
    chk(v, 8'h04);
    wreg(1'b0, 3'h0, 16'hFFFA, 8'h00);
    rd();
    chk(v, 8'h04);
    $display("test reset done");
  endtask : t_reset
  task automatic t_div();
    for (int c = 0; c < 5; c++) begin
      wreg(1'b0, 3'h0, 16'hFFFB, 8'(c));
      cyc(40);
      t0 = ticks;
      cyc(64);
      chk(8'(ticks - t0), 8'(64 >> c));
    end
    wreg(1'b1, 3'h2, 16'hFFFB, 8'h00);
    rd();
    chk(v, 8'h00);
    $display("test divider done");
  endtask : t_div
  task automatic t_sub();
    wreg(1'b0, 3'h0, 16'hFFFB, 8'h90);
    poll(1'b1);
    chk(v, 8'hB0);
    cyc(3);
    chk(main_osc_run, 1'b0);
    chk(wdt_count_en, 1'b0);
    chk(sub_osc_run, 1'b1);
    t0 = ticks;
    cyc(320);
    chk(8'(ticks - t0), 8'h08);
    pulse(0);
    cyc(2);
    chk(halted, 1'b0);
    pulse(1);
    cyc(2);
    chk(halted, 1'b1);
    t0 = ticks;
    cyc(80);
    chk(8'(ticks - t0), 8'h00);
    pulse(2);
    wreg(1'b0, 3'h0, 16'hFFFB, 8'h38);
    rd();
    chk(v, 8'h30);
    cyc(3);
    chk(main_osc_run, 1'b1);
    wreg(1'b0, 3'h0, 16'hFFFB, 8'h00);
    poll(1'b0);
    chk(v, 8'h00);
    cyc(2);
    chk(wdt_count_en, 1'b1);
    $display("test subclock done");
  endtask : t_sub
  task automatic t_stop();
    wreg(1'b0, 3'h0, 16'hFFFB, 8'h80);
    rd();
    chk(v, 8'h80);
    chk(main_osc_run, 1'b1);
    pulse(0);
    cyc(3);
    chk(halted, 1'b1);
    chk(main_osc_run, 1'b0);
    pulse(2);
    cyc(3);
    chk(halted, 1'b0);
    pulse(1);
    cyc(3);
    chk(halted, 1'b1);
    chk(main_osc_run, 1'b1);
    pulse(2);
    $display("test standby done");
  endtask : t_stop
  task automatic t_rst_mid();
    wreg(1'b0, 3'h0, 16'hFFFB, 8'h01);
    reset_n = 1'b0;
    cyc(2);
    chk(main_osc_run, 1'b0);
    chk(sub_osc_run, 1'b1);
    chk(rdata, 8'h04);
    chk(cpu_run, 1'b0);
    reset_n = 1'b1;
    t_reset();
    $display("test mid reset done");
  endtask : t_rst_mid
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    n_errors = 0;
    num_checks = 0;
    {reset_n, rd_en, stop_instr, halt_instr, wake} = 5'h00;
    wr = '0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_div();
    t_sub();
    t_stop();
    t_rst_mid();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
endmodule : tb_top
bind ccs_clock_select ccs_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .wr(wr),
  .rd_en(rd_en), .stop_instr(stop_instr), .halt_instr(halt_instr), .wake(wake),
  .sub_clk_in(sub_clk_in), .rdata(rdata), .cpu_clk_en(cpu_clk_en), .cpu_run(cpu_run),
  .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run), .halted(halted),
  .wdt_count_en(wdt_count_en));
`default_nettype wire
